// *** shared/rln_params.svh ***
// offsets, field positions, reset values and address limits of the rotate unit
`ifndef RLN_PARAMS_SVH
`define RLN_PARAMS_SVH

`define RLN_ADDR_W 12
`define RLN_MEM_DEPTH 4096
`define RLN_OFS_CTRL 8'h00
`define RLN_OFS_INSTR 8'h04
`define RLN_OFS_WREG 8'h08
`define RLN_OFS_BANK 8'h0C
`define RLN_OFS_STATUS 8'h10
`define RLN_OFS_IDX_BASE 8'h14
`define RLN_OFS_MEM_ADDR 8'h18
`define RLN_OFS_MEM_DATA 8'h1C
`define RLN_OPCODE_TOP 6'h11
`define RLN_IDX_LIMIT 8'h5F
`define RLN_ACC_HIGH_PAGE 4'hF
`define RLN_ACC_LOW_PAGE 4'h0
`define RLN_CTRL_XINST_BIT 0
`define RLN_ST_ZERO_BIT 0
`define RLN_ST_NEG_BIT 1
`define RLN_ST_BUSY_BIT 2
`define RLN_ST_BADOP_BIT 3
`define RLN_RESET_BYTE 8'h00
`define RLN_RESET_BANK 4'h0
`define RLN_RESET_ADDR 12'h000

`endif

// *** shared/rln_pkg.sv ***
// types shared by the rotate unit
package rln_pkg;

	// fields of one byte-oriented opcode word
	typedef struct packed
	{
		logic [5:0] top;
		logic dest_file;
		logic banked;
		logic [7:0] faddr;
	} rln_op_t;

	// result of the rotate datapath
	typedef struct packed
	{
		logic [7:0] value;
		logic neg;
		logic zero;
	} rln_alu_t;

	// phases of one instruction cycle
	typedef enum logic [2:0]
	{
		PH_IDLE,
		PH_DECODE,
		PH_READ,
		PH_PROCESS,
		PH_WRITE
	} rln_phase_t;

endpackage

// *** hdl/rln_rotate_alu.sv ***
// rotate-left datapath with negative and zero flags
`timescale 1ns/1ps

module rln_rotate_alu
(
	// operand
	input wire logic [7:0] src,
	// result and flags
	output rln_pkg::rln_alu_t res
);

	// bit n moves to n+1, bit 7 wraps to bit 0; carry is never touched
	always_comb
	begin
		res.value = {src[6:0], src[7]};
		res.neg = src[6];
		res.zero = (src == 8'h00);
	end

endmodule

// *** hdl/rln_exec.sv ***
// rotate-left-no-carry instruction unit with apb register access
// Notes on behaviour
// - The file byte is rotated left by one, bit 7 into bit 0, and carry is not involved.
// - With destination bit zero the result goes to the working register and the file byte stays.
// - With destination bit one the result is written back to the file byte it came from.
// - With bank bit zero the 8-bit address is resolved inside the access bank.
// - With bank bit one the bank select register supplies the bank number above the address.
// - With extended set on and bank bit zero, addresses up to 95 are offsets from the index base.
`timescale 1ns/1ps
`include "rln_params.svh"

module rln_exec
(
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);

	// file register space
	logic [7:0] mem [0:`RLN_MEM_DEPTH-1];

	logic xinst_en;
	logic [7:0] wreg;
	logic [3:0] bank_select_register;
	logic [`RLN_ADDR_W-1:0] idx_base;
	logic [`RLN_ADDR_W-1:0] mem_addr;
	logic flag_n;
	logic flag_z;
	logic bad_op;
	rln_pkg::rln_phase_t phase;
	rln_pkg::rln_op_t op;
	logic [`RLN_ADDR_W-1:0] eff_addr;
	logic [7:0] rd_byte;
	rln_pkg::rln_alu_t alu_res;
	rln_pkg::rln_alu_t alu_q;
	logic busy;
	logic acc_req;
	logic acc_done;
	logic wr_done;
	logic err_now;
	logic [31:0] next_prdata;
	rln_pkg::rln_op_t new_op;

	assign busy = (phase != rln_pkg::PH_IDLE);
	assign acc_req = psel & penable & ~pready;
	assign acc_done = psel & penable & pready;
	assign wr_done = acc_done & pwrite & ~pslverr;
	assign new_op = rln_pkg::rln_op_t'(pwdata[15:0]);

	// map an 8-bit operand address onto the 12-bit file space
	function automatic logic [`RLN_ADDR_W-1:0] resolve
	(
		input rln_pkg::rln_op_t o,
		input logic xin,
		input logic [3:0] bank,
		input logic [`RLN_ADDR_W-1:0] base
	);
		logic [`RLN_ADDR_W-1:0] r;
		r = {`RLN_ACC_LOW_PAGE, o.faddr};
		if (o.banked)
			r = {bank, o.faddr};
		else if (xin && (o.faddr <= `RLN_IDX_LIMIT))
			r = base + {4'h0, o.faddr};
		else if (o.faddr > `RLN_IDX_LIMIT)
			r = {`RLN_ACC_HIGH_PAGE, o.faddr};
		return r;
	endfunction

	// true when a write to this offset must be refused
	function automatic logic write_refused
	(
		input logic [7:0] a,
		input logic bsy,
		input rln_pkg::rln_op_t o
	);
		logic r;
		r = 1'b0;
		case (a)
			`RLN_OFS_CTRL, `RLN_OFS_WREG, `RLN_OFS_BANK,
			`RLN_OFS_IDX_BASE, `RLN_OFS_MEM_ADDR, `RLN_OFS_MEM_DATA: r = bsy;
			`RLN_OFS_INSTR: r = bsy | (o.top != `RLN_OPCODE_TOP);
			default: r = 1'b1;
		endcase
		return r;
	endfunction

	// rotate datapath
	rln_rotate_alu u_alu
	(
		.src(rd_byte),
		.res(alu_res)
	);

	// read mux for the apb slave
	always_comb
	begin
		next_prdata = 32'h0000_0000;
		err_now = 1'b0;
		if (pwrite)
			err_now = write_refused(paddr, busy, new_op);
		else
		begin
			case (paddr)
				`RLN_OFS_CTRL: next_prdata[`RLN_CTRL_XINST_BIT] = xinst_en;
				`RLN_OFS_INSTR: next_prdata[15:0] = op;
				`RLN_OFS_WREG: next_prdata[7:0] = wreg;
				`RLN_OFS_BANK: next_prdata[3:0] = bank_select_register;
				`RLN_OFS_STATUS:
				begin
					next_prdata[`RLN_ST_ZERO_BIT] = flag_z;
					next_prdata[`RLN_ST_NEG_BIT] = flag_n;
					next_prdata[`RLN_ST_BUSY_BIT] = busy;
					next_prdata[`RLN_ST_BADOP_BIT] = bad_op;
				end
				`RLN_OFS_IDX_BASE: next_prdata[`RLN_ADDR_W-1:0] = idx_base;
				`RLN_OFS_MEM_ADDR: next_prdata[`RLN_ADDR_W-1:0] = mem_addr;
				`RLN_OFS_MEM_DATA: next_prdata[7:0] = mem[mem_addr];
				default: err_now = 1'b1;
			endcase
		end
	end

	// apb answer: ready one cycle into the access phase
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end
		else
		begin
			pready <= acc_req;
			pslverr <= acc_req & err_now;
			if (acc_req)
				prdata <= next_prdata;
		end
	end

	// software-written configuration
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			xinst_en <= 1'b0;
			bank_select_register <= `RLN_RESET_BANK;
			idx_base <= `RLN_RESET_ADDR;
			mem_addr <= `RLN_RESET_ADDR;
		end
		else if (wr_done)
		begin
			case (paddr)
				`RLN_OFS_CTRL: xinst_en <= pwdata[`RLN_CTRL_XINST_BIT];
				`RLN_OFS_BANK: bank_select_register <= pwdata[3:0];
				`RLN_OFS_IDX_BASE: idx_base <= pwdata[`RLN_ADDR_W-1:0];
				`RLN_OFS_MEM_ADDR: mem_addr <= pwdata[`RLN_ADDR_W-1:0];
				default: ;
			endcase
		end
	end

	// foreign opcodes written while idle are remembered until the next accepted one
	always_ff @(posedge clock)
	begin
		if (rst)
			bad_op <= 1'b0;
		else if (acc_done && pwrite && paddr == `RLN_OFS_INSTR && !busy)
			bad_op <= (new_op.top != `RLN_OPCODE_TOP);
	end

	// four-phase sequencer: decode, read, process, write
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			phase <= rln_pkg::PH_IDLE;
			op <= '0;
		end
		else
		begin
			case (phase)
				rln_pkg::PH_IDLE:
					if (wr_done && paddr == `RLN_OFS_INSTR)
					begin
						op <= new_op;
						phase <= rln_pkg::PH_DECODE;
					end
				rln_pkg::PH_DECODE: phase <= rln_pkg::PH_READ;
				rln_pkg::PH_READ: phase <= rln_pkg::PH_PROCESS;
				rln_pkg::PH_PROCESS: phase <= rln_pkg::PH_WRITE;
				rln_pkg::PH_WRITE: phase <= rln_pkg::PH_IDLE;
				default: phase <= rln_pkg::PH_IDLE;
			endcase
		end
	end

	// operand address, source byte and processed result
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			eff_addr <= `RLN_RESET_ADDR;
			rd_byte <= `RLN_RESET_BYTE;
			alu_q <= '0;
		end
		else
		begin
			if (phase == rln_pkg::PH_DECODE)
				eff_addr <= resolve(op, xinst_en, bank_select_register, idx_base);
			if (phase == rln_pkg::PH_READ)
				rd_byte <= mem[eff_addr];
			if (phase == rln_pkg::PH_PROCESS)
				alu_q <= alu_res;
		end
	end

	// file memory: software port when idle, write-back in the write phase
	always_ff @(posedge clock)
	begin
		if (phase == rln_pkg::PH_WRITE && op.dest_file)
			mem[eff_addr] <= alu_q.value;
		else if (wr_done && paddr == `RLN_OFS_MEM_DATA)
			mem[mem_addr] <= pwdata[7:0];
	end

	// working register
	always_ff @(posedge clock)
	begin
		if (rst)
			wreg <= `RLN_RESET_BYTE;
		else if (phase == rln_pkg::PH_WRITE && !op.dest_file)
			wreg <= alu_q.value;
		else if (wr_done && paddr == `RLN_OFS_WREG)
			wreg <= pwdata[7:0];
	end

	// only negative and zero flags change; no carry exists here
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			flag_n <= 1'b0;
			flag_z <= 1'b0;
		end
		else if (phase == rln_pkg::PH_WRITE)
		begin
			flag_n <= alu_q.neg;
			flag_z <= alu_q.zero;
		end
	end

endmodule

// *** tb/rln_exec_properties.sv ***
// protocol and refusal checks on the rotate unit's apb port
`timescale 1ns/1ps

module rln_exec_properties
(
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// apb slave side
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	// access phase still waiting for its answer
	wire logic acc = psel && penable && !pready;
	chk_ready_next: assert property (acc |=> pready)
		else $error("no ready one cycle into access");
	chk_ready_pulse: assert property (pready |=> !pready)
		else $error("ready held longer than one cycle");
	chk_idle_quiet: assert property (!psel |=> !pready)
		else $error("ready without a selected transfer");
	chk_err_with_ready: assert property (pslverr |-> pready)
		else $error("error flag without ready");
	chk_status_ro: assert property (acc && pwrite && paddr == 8'h10 |=> pslverr)
		else $error("status write accepted");
	chk_bad_opcode: assert property (acc && pwrite && paddr == 8'h04
		&& pwdata[15:10] != 6'h11 |=> pslverr)
		else $error("foreign opcode accepted");
	chk_wreg_read: assert property (acc && !pwrite && paddr == 8'h08 |=> !pslverr)
		else $error("working register read refused");
	chk_bank_read: assert property (acc && !pwrite && paddr == 8'h0C |=> !pslverr)
		else $error("bank select read refused");
	// read data only moves at the edge that raises ready
	chk_rdata_hold: assert property (!acc |=> $stable(prdata))
		else $error("read data changed outside an access");
endmodule

// *** tb/rln_exec_bench.sv ***
// self-checking bench for the rotate instruction unit
`timescale 1ns/1ps

module rln_exec_bench;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	int errors = 0;
	int n_compared = 0;
	integer seed = 32'hC449;
	logic [31:0] rd;
	logic er;
	int i;
	int k;
	logic [7:0] v, f, r, w;
	logic d, a, x;
	logic [3:0] bk;
	logic [11:0] ix, ad;

	// clock generation
	always #5 clock = ~clock;

	rln_exec dut (.clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

	// one comparison of expected against design value
	task automatic compare(input logic [31:0] e, input logic [31:0] g);
	begin
		n_compared++;
		if (g !== e)
		begin
			errors++;
			$display("mismatch at %0t exp %h got %h", $time, e, g);
		end
	end
	endtask

	// counts and verdict
	task summarize;
	begin
		$display("errors %0d compared %0d", errors, n_compared);
		if (errors == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	end
	endtask

	// one apb transfer, holds the request until ready is sampled high
	task automatic apb(input logic wr, input logic [7:0] ad8, input logic [31:0] dat);
		int n;
	begin
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= ad8;
		pwdata <= dat;
		@(posedge clock);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clock);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		// a missing answer ends the run as a failure
		if (pready !== 1'b1)
		begin
			errors++;
			summarize();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	end
	endtask

	// watchdog
	initial
	begin
		repeat (30000) @(posedge clock);
		errors++;
		summarize();
	end

	// main sequence
	initial
	begin
		repeat (8) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		apb(1'b0, 8'h20, 32'h0);
		compare(32'h1, {31'h0, er});
		apb(1'b1, 8'h10, 32'h0);
		compare(32'h1, {31'h0, er});
		apb(1'b1, 8'h04, 32'h00004C00);
		compare(32'h1, {31'h0, er});
		apb(1'b0, 8'h10, 32'h0);
		compare(32'h1, {31'h0, rd[3]});
		for (i = 0; i < 40; i++)
		begin
			v = (i < 2) ? 8'(i * 128) : 8'($random(seed));
			f = 8'($random(seed));
			w = 8'($random(seed));
			{d, a, x, bk} = 7'($random(seed));
			ix = 12'($random(seed));
			ad = a ? {bk, f} : (x && f <= 8'h5F) ? ix + {4'h0, f}
				: (f <= 8'h5F ? {4'h0, f} : {4'hF, f});
			r = {v[6:0], v[7]};
			apb(1'b1, 8'h00, {31'h0, x});
			apb(1'b1, 8'h0C, {28'h0, bk});
			apb(1'b1, 8'h14, {20'h0, ix});
			apb(1'b1, 8'h08, {24'h0, w});
			apb(1'b1, 8'h18, {20'h0, ad});
			apb(1'b1, 8'h1C, {24'h0, v});
			apb(1'b1, 8'h04, {16'h0, 6'h11, d, a, f});
			compare(32'h0, {31'h0, er});
			apb(1'b1, 8'h08, {24'h0, ~w});
			compare(32'h1, {31'h0, er});
			k = 0;
			do
			begin
				apb(1'b0, 8'h10, 32'h0);
				k++;
			end
			while (rd[2] !== 1'b0 && k < 20);
			compare({30'h0, r[7], r == 8'h00}, rd);
			apb(1'b0, 8'h08, 32'h0);
			compare({24'h0, d ? w : r}, rd);
			apb(1'b0, 8'h1C, 32'h0);
			compare({24'h0, d ? r : v}, rd);
			apb(1'b0, 8'h04, 32'h0);
			compare({16'h0, 6'h11, d, a, f}, rd);
			apb(1'b0, 8'h0C, 32'h0);
			compare({28'h0, bk}, rd);
			apb(1'b0, 8'h14, 32'h0);
			compare({20'h0, ix}, rd);
			apb(1'b0, 8'h00, 32'h0);
			compare({31'h0, x}, rd);
		end
		summarize();
	end
endmodule

bind rln_exec rln_exec_properties chk (.clock(clock), .rst(rst), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr));
